/* File: design/cdrlt_pkg.sv */
package cdrlt_pkg;
   localparam logic [7:0] ADDR_SIGNAL_LOSS_POWER = 8'h09;
   localparam logic [7:0] ADDR_EDGE_BANDWIDTH = 8'h10;
   localparam logic [7:0] ADDR_LOOP_SLEW = 8'h13;
   localparam logic [7:0] ADDR_SAMPLE_PHASE = 8'h14;
   localparam logic [7:0] ADDR_SLICE_LEVEL = 8'h15;
   localparam logic [7:0] ADDR_EQUALIZER = 8'h16;
   localparam logic [7:0] ADDR_LEVEL_DATA = 8'h36;
   localparam logic [7:0] ADDR_LEVEL_CONTROL = 8'h74;

   localparam int POWERDOWN_BIT = 3;
   localparam int EDGE_SEL_LSB = 3;
   localparam int BANDWIDTH_LSB = 0;
   localparam int SLEW_LSB = 0;
   localparam int PHASE_LSB = 0;
   localparam int EQ_MANUAL_BIT = 4;
   localparam int EQ_VALUE_LSB = 0;
   localparam int STROBE_BIT = 4;
   localparam int INDEX_LSB = 0;

   localparam logic [1:0] EDGE_RISING = 2'h1;
   localparam logic [1:0] EDGE_FALLING = 2'h2;
   localparam logic [1:0] SLEW_REDUCED = 2'h0;
   localparam logic [2:0] INDEX_THRESHOLD = 3'h1;
   localparam logic [2:0] INDEX_AMPLITUDE = 3'h7;

   localparam logic [7:0] RESET_SIGNAL_LOSS_POWER = 8'h00;
   localparam logic [7:0] RESET_EDGE_BANDWIDTH = 8'h04;
   localparam logic [7:0] RESET_LOOP_SLEW = 8'h02;
   localparam logic [7:0] RESET_SAMPLE_PHASE = 8'h00;
   localparam logic [7:0] RESET_SLICE_LEVEL = 8'h00;
   localparam logic [7:0] RESET_EQUALIZER = 8'h00;
   localparam logic [7:0] RESET_LEVEL_DATA = 8'h00;
   localparam logic [7:0] RESET_LEVEL_CONTROL = 8'h00;
   localparam logic [7:0] RESET_THRESHOLD = 8'h10;

   localparam logic [7:0] THRESHOLD_MAX_MV = 8'h80;
   localparam logic [7:0] THRESHOLD_COARSE_MV = 8'h40;
endpackage : cdrlt_pkg

/* File: design/cdrlt_tuning.sv */
// What this block does
// - Edge field 1 rising only, 2 falling only
// - Slew bits 1:0 of 0x13, reset 2
// - Slew 0 selects reduced-slew behaviour
// - Phase bits 3:0 of 0x14, high rate only
// - Phase is signed offset, 1/32 UI steps
// - Bandwidth bits 2:0 of 0x10, reset 4
// - Bandwidth scales as field over four
// - Lost below threshold, clears at twice threshold
// - Measurement uses absolute level, ignores slice offset
// - Monitor on after reset; bit 3 powers down
// - Threshold 0-128 mV, bit 0 dropped above 63
// - Threshold committed by index 1 strobe toggle
// - Strobe fall at index 7, after a rise at index 7, loads amplitude
// - Data changes only on index 7 toggle or a write to 0x36
// - Adaptive equalizer default, manual via 0x16
`timescale 1ns/10ps
`default_nettype none
module cdrlt_tuning (
   input wire logic clock,
   input wire logic reset,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_write_data,
   output logic [7:0] reg_read_data,
   input wire logic [7:0] input_level_mv,
   input wire logic rate_high,
   input wire logic [3:0] eq_adaptive_setting,
   output logic input_signal_lost,
   output logic signal_monitor_powerdown,
   output logic align_rising_only,
   output logic align_falling_only,
   output logic [1:0] dll_slew,
   output logic reduced_slew,
   output logic [2:0] slew_track_quarter_ui,
   output logic signed [3:0] sample_phase_offset,
   output logic [2:0] transfer_bandwidth_sel,
   output logic [6:0] slice_level,
   output logic eq_manual,
   output logic [3:0] eq_setting,
   output logic [7:0] signal_loss_threshold
);
   typedef struct packed {
      logic [7:0] power_cfg;
      logic [7:0] edge_bw;
      logic [7:0] slew;
      logic [7:0] phase;
      logic [7:0] slice;
      logic [7:0] eq;
      logic [7:0] level_data;
      logic [7:0] level_ctrl;
      logic [7:0] threshold;
      logic lost;
      logic armed;
      logic [7:0] read_data;
   } cdrlt_state_s;

   cdrlt_state_s state;
   cdrlt_state_s next_state;

   // Coarse range loses its lowest bit; values above full scale clamp
   function automatic logic [7:0] cdrlt_quantize(input logic [7:0] mv);
      logic [7:0] q;
      q = (mv > cdrlt_pkg::THRESHOLD_MAX_MV) ? cdrlt_pkg::THRESHOLD_MAX_MV : mv;
      if (q >= cdrlt_pkg::THRESHOLD_COARSE_MV) begin
         q[0] = 1'b0;
      end
      return q;
   endfunction : cdrlt_quantize

   logic write_ctrl;
   logic strobe_now;
   logic strobe_next;
   logic [2:0] index_next;
   logic strobe_rise;
   logic strobe_fall;
   logic [8:0] double_threshold;

   assign write_ctrl = reg_write && (reg_addr == cdrlt_pkg::ADDR_LEVEL_CONTROL);
   assign strobe_now = state.level_ctrl[cdrlt_pkg::STROBE_BIT];
   assign strobe_next = reg_write_data[cdrlt_pkg::STROBE_BIT];
   assign index_next = reg_write_data[cdrlt_pkg::INDEX_LSB +: 3];
   assign strobe_rise = write_ctrl && !strobe_now && strobe_next;
   assign strobe_fall = write_ctrl && strobe_now && !strobe_next;
   assign double_threshold = {state.threshold, 1'b0};

   always_comb begin
      next_state = state;
      if (reg_write) begin
         unique case (reg_addr)
            cdrlt_pkg::ADDR_SIGNAL_LOSS_POWER: next_state.power_cfg = reg_write_data;
            cdrlt_pkg::ADDR_EDGE_BANDWIDTH: next_state.edge_bw = reg_write_data;
            cdrlt_pkg::ADDR_LOOP_SLEW: next_state.slew = reg_write_data;
            cdrlt_pkg::ADDR_SAMPLE_PHASE: next_state.phase = reg_write_data;
            cdrlt_pkg::ADDR_SLICE_LEVEL: next_state.slice = reg_write_data;
            cdrlt_pkg::ADDR_EQUALIZER: next_state.eq = reg_write_data;
            cdrlt_pkg::ADDR_LEVEL_DATA: next_state.level_data = reg_write_data;
            cdrlt_pkg::ADDR_LEVEL_CONTROL: next_state.level_ctrl = reg_write_data;
            default: ;
         endcase
      end
      // Commit taken on the falling edge of the strobe, the last step of the sequence
      if (strobe_fall && index_next == cdrlt_pkg::INDEX_THRESHOLD) begin
         next_state.threshold = cdrlt_quantize(state.level_data);
      end
      // Amplitude load needs a full low-high-low toggle at index 7
      if (strobe_rise) begin
         next_state.armed = (index_next == cdrlt_pkg::INDEX_AMPLITUDE);
      end else if (write_ctrl && index_next != cdrlt_pkg::INDEX_AMPLITUDE) begin
         next_state.armed = 1'b0;
      end
      if (strobe_fall && state.armed && index_next == cdrlt_pkg::INDEX_AMPLITUDE) begin
         next_state.level_data = input_level_mv;
         next_state.armed = 1'b0;
      end
      // Hysteresis: assert below threshold, release at twice it or on power-down
      if (state.power_cfg[cdrlt_pkg::POWERDOWN_BIT]) begin
         next_state.lost = 1'b0;
      end else if ({1'b0, input_level_mv} >= double_threshold) begin
         next_state.lost = 1'b0;
      end else if (input_level_mv < state.threshold) begin
         next_state.lost = 1'b1;
      end
      next_state.read_data = 8'h00;
      if (reg_read) begin
         unique case (reg_addr)
            cdrlt_pkg::ADDR_SIGNAL_LOSS_POWER: next_state.read_data = state.power_cfg;
            cdrlt_pkg::ADDR_EDGE_BANDWIDTH: next_state.read_data = state.edge_bw;
            cdrlt_pkg::ADDR_LOOP_SLEW: next_state.read_data = state.slew;
            cdrlt_pkg::ADDR_SAMPLE_PHASE: next_state.read_data = state.phase;
            cdrlt_pkg::ADDR_SLICE_LEVEL: next_state.read_data = state.slice;
            cdrlt_pkg::ADDR_EQUALIZER: next_state.read_data = state.eq;
            cdrlt_pkg::ADDR_LEVEL_DATA: next_state.read_data = state.level_data;
            cdrlt_pkg::ADDR_LEVEL_CONTROL: next_state.read_data = state.level_ctrl;
            default: next_state.read_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state.power_cfg <= cdrlt_pkg::RESET_SIGNAL_LOSS_POWER;
         state.edge_bw <= cdrlt_pkg::RESET_EDGE_BANDWIDTH;
         state.slew <= cdrlt_pkg::RESET_LOOP_SLEW;
         state.phase <= cdrlt_pkg::RESET_SAMPLE_PHASE;
         state.slice <= cdrlt_pkg::RESET_SLICE_LEVEL;
         state.eq <= cdrlt_pkg::RESET_EQUALIZER;
         state.level_data <= cdrlt_pkg::RESET_LEVEL_DATA;
         state.level_ctrl <= cdrlt_pkg::RESET_LEVEL_CONTROL;
         state.threshold <= cdrlt_pkg::RESET_THRESHOLD;
         state.lost <= 1'b0;
         state.armed <= 1'b0;
         state.read_data <= 8'h00;
      end else begin
         state <= next_state;
      end
   end

   logic [1:0] edge_sel;
   assign edge_sel = state.edge_bw[cdrlt_pkg::EDGE_SEL_LSB +: 2];
   assign align_rising_only = (edge_sel == cdrlt_pkg::EDGE_RISING);
   assign align_falling_only = (edge_sel == cdrlt_pkg::EDGE_FALLING);
   assign dll_slew = state.slew[cdrlt_pkg::SLEW_LSB +: 2];
   assign reduced_slew = (dll_slew == cdrlt_pkg::SLEW_REDUCED);
   // Tracking amplitude in quarter UI: one plus the slew code
   assign slew_track_quarter_ui = {1'b0, dll_slew} + 3'h1;
   // Below the rate limit the sampler stays at its own default point
   assign sample_phase_offset = rate_high ? signed'(state.phase[cdrlt_pkg::PHASE_LSB +: 4]) : 4'sh0;
   // Loop gain is this code over four; zero opens the loop and is left to the host
   assign transfer_bandwidth_sel = state.edge_bw[cdrlt_pkg::BANDWIDTH_LSB +: 3];
   assign slice_level = state.slice[6:0];
   assign eq_manual = state.eq[cdrlt_pkg::EQ_MANUAL_BIT];
   assign eq_setting = eq_manual ? state.eq[cdrlt_pkg::EQ_VALUE_LSB +: 4] : eq_adaptive_setting;
   assign signal_monitor_powerdown = state.power_cfg[cdrlt_pkg::POWERDOWN_BIT];
   assign input_signal_lost = state.lost;
   assign signal_loss_threshold = state.threshold;
   assign reg_read_data = state.read_data;

   // All checks live in the one clock domain, so reset gating is declared once
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   // Values seen at the first edge after reset release
   chk_slew_reset: assert property ($fell(reset) |-> dll_slew == 2'h2)
      else $error("slew field not 2 after reset");

   chk_bw_reset: assert property ($fell(reset) |-> transfer_bandwidth_sel == 3'h4)
      else $error("bandwidth field not 4 after reset");

   chk_monitor_on: assert property ($fell(reset) |-> !signal_monitor_powerdown)
      else $error("monitor powered down after reset");

   chk_reset_threshold: assert property ($fell(reset) |-> signal_loss_threshold == 8'h10)
      else $error("threshold not at reset value after reset");

   chk_reset_lost: assert property ($fell(reset) |-> !input_signal_lost)
      else $error("loss flagged straight after reset");

   // Edge selection decodes
   chk_edge_exclusive: assert property (!(align_rising_only && align_falling_only))
      else $error("both edge modes active");

   chk_rising_decode: assert property (state.edge_bw[4:3] == 2'h1 |-> align_rising_only)
      else $error("rising edge mode not selected");

   chk_falling_decode: assert property (state.edge_bw[4:3] == 2'h2 |-> align_falling_only)
      else $error("falling edge mode not selected");

   // Slew and tracking
   chk_reduced_slew: assert property (reduced_slew == (state.slew[1:0] == 2'h0))
      else $error("reduced slew decode wrong");

   chk_track_scale: assert property (state.slew[1:0] == 2'h2 |-> slew_track_quarter_ui == 3'h3)
      else $error("default slew does not track three quarters");

   chk_write_takes: assert property (reg_write && reg_addr == cdrlt_pkg::ADDR_LOOP_SLEW
      |=> dll_slew == $past(reg_write_data[1:0]))
      else $error("slew write not applied");

   // Sample phase only at high rate
   chk_phase_low_rate: assert property (!rate_high |-> sample_phase_offset == 4'sh0)
      else $error("phase moved at low rate");

   chk_phase_high_rate: assert property (rate_high
      |-> sample_phase_offset == signed'(state.phase[3:0]))
      else $error("phase offset not applied at high rate");

   // Bandwidth, slice, equalizer and power writes
   chk_bw_write: assert property (reg_write && reg_addr == cdrlt_pkg::ADDR_EDGE_BANDWIDTH
      |=> transfer_bandwidth_sel == $past(reg_write_data[2:0]))
      else $error("bandwidth write not applied");

   chk_slice_write: assert property (reg_write && reg_addr == cdrlt_pkg::ADDR_SLICE_LEVEL
      |=> slice_level == $past(reg_write_data[6:0]))
      else $error("slice write not applied");

   chk_power_write: assert property (reg_write && reg_addr == cdrlt_pkg::ADDR_SIGNAL_LOSS_POWER
      |=> signal_monitor_powerdown == $past(reg_write_data[3]))
      else $error("power-down write not applied");

   chk_eq_adaptive: assert property (!eq_manual |-> eq_setting == eq_adaptive_setting)
      else $error("adaptive setting not used");

   chk_eq_manual: assert property (eq_manual |-> eq_setting == state.eq[3:0])
      else $error("manual setting not used");

   // Read path
   chk_readback: assert property (reg_write && reg_addr == cdrlt_pkg::ADDR_SAMPLE_PHASE
      ##1 reg_read && reg_addr == cdrlt_pkg::ADDR_SAMPLE_PHASE && !reg_write
      |=> reg_read_data == $past(reg_write_data, 2))
      else $error("phase read-back mismatch");

   chk_read_idle: assert property (!reg_read |=> reg_read_data == 8'h00)
      else $error("read data not cleared without read");

   // Threshold and measurement sequences
   chk_data_stable: assert property (!(reg_write && reg_addr == cdrlt_pkg::ADDR_LEVEL_DATA)
      && !(strobe_fall && index_next == cdrlt_pkg::INDEX_AMPLITUDE) |=> $stable(state.level_data))
      else $error("data register changed without toggle");

   chk_amp_load: assert property (strobe_fall && state.armed
      && index_next == cdrlt_pkg::INDEX_AMPLITUDE |=> state.level_data == $past(input_level_mv))
      else $error("amplitude not loaded");

   chk_thresh_commit: assert property (strobe_fall && index_next == cdrlt_pkg::INDEX_THRESHOLD
      |=> signal_loss_threshold == cdrlt_quantize($past(state.level_data)))
      else $error("threshold not committed");

   chk_thresh_hold: assert property (!(strobe_fall && index_next == cdrlt_pkg::INDEX_THRESHOLD)
      |=> $stable(signal_loss_threshold))
      else $error("threshold changed without commit");

   chk_thresh_quant: assert property (signal_loss_threshold <= cdrlt_pkg::THRESHOLD_MAX_MV
      && (signal_loss_threshold < cdrlt_pkg::THRESHOLD_COARSE_MV || !signal_loss_threshold[0]))
      else $error("threshold out of range or odd in coarse range");

   // Loss detector with hysteresis
   chk_lost_sets: assert property (!signal_monitor_powerdown
      && input_level_mv < signal_loss_threshold |=> input_signal_lost)
      else $error("loss not flagged below threshold");

   chk_lost_holds: assert property (input_signal_lost && !signal_monitor_powerdown
      && {1'b0, input_level_mv} < {signal_loss_threshold, 1'b0} |=> input_signal_lost)
      else $error("loss released below twice threshold");

   chk_lost_clears: assert property (!signal_monitor_powerdown
      && {1'b0, input_level_mv} >= {signal_loss_threshold, 1'b0} |=> !input_signal_lost)
      else $error("loss held at twice threshold");

   chk_lost_no_rise: assert property (!input_signal_lost
      && input_level_mv >= signal_loss_threshold |=> !input_signal_lost)
      else $error("loss flagged at or above threshold");

   // Power-down trades the flag for low power; the flag reads clear meanwhile
   chk_powerdown_clear: assert property (signal_monitor_powerdown |=> !input_signal_lost)
      else $error("loss flagged while powered down");

   cov_threshold_commit: cover property (strobe_fall && index_next == cdrlt_pkg::INDEX_THRESHOLD);

   cov_amplitude_load: cover property (strobe_fall && state.armed && index_next == cdrlt_pkg::INDEX_AMPLITUDE);

   cov_loss_cycle: cover property ($rose(input_signal_lost) ##[1:50] $fell(input_signal_lost));

   cov_reduced_slew: cover property (reduced_slew && rate_high && sample_phase_offset != 4'sh0);

   cov_manual_eq: cover property (eq_manual && eq_setting != eq_adaptive_setting);
endmodule : cdrlt_tuning
`default_nettype wire

/* File: tb/cdrlt_host.sv */
`timescale 1ns/10ps
`default_nettype none
module cdrlt_host (
   input wire logic clock,
   output logic reg_write,
   output logic reg_read,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_write_data,
   input wire logic [7:0] reg_read_data
);
   initial begin
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h00;
      reg_write_data = 8'h00;
   end
   // Idle bus shows inverted values so a stale address is never mistaken for live
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_write = 1'b1;
      reg_addr = a;
      reg_write_data = d;
      @(negedge clock);
      reg_write = 1'b0;
      reg_addr = ~a;
      reg_write_data = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      reg_read = 1'b1;
      reg_addr = a;
      @(negedge clock);
      reg_read = 1'b0;
      reg_addr = ~a;
      d = reg_read_data;
   endtask : rd
   // Write then read the same register on the very next cycle
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge clock);
      reg_write = 1'b1;
      reg_addr = a;
      reg_write_data = d;
      @(negedge clock);
      reg_write = 1'b0;
      reg_write_data = ~d;
      reg_read = 1'b1;
      @(negedge clock);
      reg_read = 1'b0;
      reg_addr = ~a;
      q = reg_read_data;
   endtask : wr_rd
   task automatic set_threshold(input logic [7:0] mv);
      wr(cdrlt_pkg::ADDR_LEVEL_CONTROL, 8'h21);
      wr(cdrlt_pkg::ADDR_LEVEL_DATA, mv);
      wr(cdrlt_pkg::ADDR_LEVEL_CONTROL, 8'h31);
      wr(cdrlt_pkg::ADDR_LEVEL_CONTROL, 8'h21);
   endtask : set_threshold
   task automatic strobe(input logic [2:0] idx);
      wr(cdrlt_pkg::ADDR_LEVEL_CONTROL, {5'h00, idx});
      wr(cdrlt_pkg::ADDR_LEVEL_CONTROL, {5'h02, idx});
      wr(cdrlt_pkg::ADDR_LEVEL_CONTROL, {5'h00, idx});
   endtask : strobe
endmodule : cdrlt_host
`default_nettype wire

/* File: tb/test_cdr_loop_tuning_and_signal_loss_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module test_cdr_loop_tuning_and_signal_loss_ctrl;
   logic clock, reset, reg_write, reg_read, rate_high, lost, pdn, rise, fall, red, eq_manual;
   logic [7:0] reg_addr, reg_write_data, reg_read_data, input_level_mv, thr, rdata, lvl;
   logic [3:0] eq_adaptive_setting, eq_setting;
   logic signed [3:0] phase;
   logic [1:0] slew;
   logic [2:0] track, bw, bwv;
   logic [6:0] slice;
   logic [31:0] v;
   logic [7:0] lv [6] = '{8'h3e, 8'h7d, 8'h7e, 8'h3f, 8'h10, 8'h7d};
   logic lx [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   int n_mismatch = 0;
   int checks = 0;
   cdrlt_host host (.clock(clock), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
      .reg_write_data(reg_write_data), .reg_read_data(reg_read_data));
   cdrlt_tuning uut (.clock(clock), .reset(reset), .reg_write(reg_write), .reg_read(reg_read),
      .reg_addr(reg_addr), .reg_write_data(reg_write_data), .reg_read_data(reg_read_data),
      .input_level_mv(input_level_mv), .rate_high(rate_high), .eq_adaptive_setting(eq_adaptive_setting),
      .input_signal_lost(lost), .signal_monitor_powerdown(pdn), .align_rising_only(rise),
      .align_falling_only(fall), .dll_slew(slew), .reduced_slew(red), .slew_track_quarter_ui(track),
      .sample_phase_offset(phase), .transfer_bandwidth_sel(bw), .slice_level(slice),
      .eq_manual(eq_manual), .eq_setting(eq_setting), .signal_loss_threshold(thr));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, rdata);
      chk(rdata, exp);
   endtask : rdchk
   // Clamp first, then coarse range drops bit 0
   function automatic logic [7:0] thr_exp(input logic [7:0] mv);
      logic [7:0] c;
      c = (mv > 8'h80) ? 8'h80 : mv;
      return (c >= 8'h40) ? {c[7:1], 1'b0} : c;
   endfunction : thr_exp
   task automatic end_sim;
      if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      #200000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      reset = 1'b1;
      input_level_mv = 8'h00;
      rate_high = 1'b0;
      eq_adaptive_setting = 4'h5;
      v = $urandom(32'ha4b3d14a);
      repeat (8) @(negedge clock);
      reset = 1'b0;
      rdchk(cdrlt_pkg::ADDR_SIGNAL_LOSS_POWER, cdrlt_pkg::RESET_SIGNAL_LOSS_POWER);
      rdchk(cdrlt_pkg::ADDR_EDGE_BANDWIDTH, cdrlt_pkg::RESET_EDGE_BANDWIDTH);
      rdchk(cdrlt_pkg::ADDR_LOOP_SLEW, cdrlt_pkg::RESET_LOOP_SLEW);
      rdchk(cdrlt_pkg::ADDR_EQUALIZER, cdrlt_pkg::RESET_EQUALIZER);
      rdchk(8'h20, 8'h00);
      chk({4'h0, eq_setting}, 8'h05);
      chk({7'h00, pdn}, 8'h00);
      for (int i = 0; i < 24; i++) begin
         v = $urandom;
         rate_high = v[7];
         bwv = (v[14:12] == 3'h0) ? 3'h1 : v[14:12];
         host.wr(cdrlt_pkg::ADDR_LOOP_SLEW, {6'h00, v[1:0]});
         chk({6'h00, slew}, {6'h00, v[1:0]});
         chk({7'h00, red}, {7'h00, v[1:0] == 2'h0});
         chk({5'h00, track}, {5'h00, 3'(v[1:0]) + 3'h1});
         host.wr(cdrlt_pkg::ADDR_EDGE_BANDWIDTH, {3'h0, v[4:3], bwv});
         chk({6'h00, rise, fall}, {6'h00, v[4:3] == 2'h1, v[4:3] == 2'h2});
         chk({5'h00, bw}, {5'h00, bwv});
         host.wr_rd(cdrlt_pkg::ADDR_SAMPLE_PHASE, {4'h0, v[11:8]}, rdata);
         chk(rdata, {4'h0, v[11:8]});
         chk({4'h0, phase}, {4'h0, v[7] ? v[11:8] : 4'h0});
         rdchk(cdrlt_pkg::ADDR_SAMPLE_PHASE, {4'h0, v[11:8]});
      end
      foreach (lv[i]) begin
         if (i < 3) host.set_threshold(lv[5 - i] + 8'h4b * i[7:0]);
         if (i < 3) chk(thr, thr_exp(lv[5 - i] + 8'h4b * i[7:0]));
      end
      host.set_threshold(8'h3f);
      host.wr(cdrlt_pkg::ADDR_SLICE_LEVEL, {1'b0, v[22:16]});
      chk({1'b0, slice}, {1'b0, v[22:16]});
      foreach (lv[i]) begin
         input_level_mv = lv[i];
         repeat (3) @(negedge clock);
         chk({7'h00, lost}, {7'h00, lx[i]});
      end
      host.wr(cdrlt_pkg::ADDR_SIGNAL_LOSS_POWER, 8'h08);
      // Loss flag clears one cycle after the power-down bit lands
      @(negedge clock);
      chk({6'h00, pdn, lost}, 8'h02);
      lvl = $urandom;
      input_level_mv = lvl;
      host.strobe(cdrlt_pkg::INDEX_AMPLITUDE);
      rdchk(cdrlt_pkg::ADDR_LEVEL_DATA, lvl);
      input_level_mv = ~lvl;
      host.strobe(3'h2);
      rdchk(cdrlt_pkg::ADDR_LEVEL_DATA, lvl);
      eq_adaptive_setting = v[27:24];
      @(negedge clock);
      chk({3'h0, eq_manual, eq_setting}, {4'h0, v[27:24]});
      host.wr(cdrlt_pkg::ADDR_EQUALIZER, 8'h1a);
      eq_adaptive_setting = ~v[27:24];
      chk({3'h0, eq_manual, eq_setting}, 8'h1a);
      end_sim();
   end
endmodule : test_cdr_loop_tuning_and_signal_loss_ctrl
`default_nettype wire
